// *** src/acsp_device.sv ***
/*
 Codec end: makes bit clock and frame sync, shifts 64-bit frames.
 Assumes the host keeps its own timing against the frame sync.
*/
`timescale 1ns/1ns
module acsp_device
  import acsp_pkg::*;
#(
  parameter int MCLK_DIV     = ACSP_MCLK_DIV,
  parameter int FRAME_PERIOD = ACSP_FRAME_PERIOD
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  input  wire logic [7:0]  divN,
  input  wire logic        quadMode,
  input  wire logic [63:0] txWord,
  acsp_if.device           link,
  output logic             txTaken,
  output logic [63:0]      rxWord,
  output logic             rxValid,
  output logic             masterTickOut,
  output logic             modemClockTick
);
  typedef enum logic [1:0] {ACSP_IDLE, ACSP_SYNC, ACSP_DATA} acsp_state_t;
  acsp_state_t              state_reg, state_next;
  logic [7:0]               mclkCnt_reg;
  logic [9:0]               bitDivCnt_reg;
  logic                     sclk_reg, fsync_reg, sout_reg;
  logic [ACSP_CNT_W-1:0]    bitCnt_reg;
  logic [ACSP_PERIOD_W-1:0] perCnt_reg;
  logic [63:0]              shTx_reg, shRx_reg;
  logic                     modemTick_reg, mtick_reg;
  wire  [7:0]               nEff = (divN == 8'h00) ? ACSP_N_RESET : divN;
  wire  [9:0]               halfDiv = {nEff, 1'b0} - 10'd1;
  wire                      mTick = clkEn &&
                                    (mclkCnt_reg == 8'(MCLK_DIV - 1));
  wire                      halfEdge = mTick && (bitDivCnt_reg == halfDiv);
  wire                      sclkRise = halfEdge && !sclk_reg;
  wire                      sclkFall = halfEdge && sclk_reg;
  wire                      frameDue = perCnt_reg ==
                                       ACSP_PERIOD_W'(FRAME_PERIOD - 1);
  wire                      lastBit = bitCnt_reg ==
                                      ACSP_CNT_W'(ACSP_FRAME_BITS - 1);
  //////////////////////////////////////////////////////////////////////
  // Master clock and bit clock dividers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mclkCnt_reg   <= 8'h00; // see (R12)
      bitDivCnt_reg <= 10'h000;
      sclk_reg      <= 1'b0;
      mtick_reg     <= 1'b0;
      modemTick_reg <= 1'b0;
    end else if (clkEn) begin
      mclkCnt_reg   <= mTick ? 8'h00 : mclkCnt_reg + 8'h01; // see (R10)
      mtick_reg     <= mTick;
      modemTick_reg <= mTick && quadMode; // see (R11)
      if (mTick) begin
        bitDivCnt_reg <= halfEdge ? 10'h000 : bitDivCnt_reg + 10'h001;
        if (halfEdge)
          sclk_reg <= !sclk_reg; // see (R01) (R13)
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACSP_IDLE: if (sclkRise && frameDue) state_next = ACSP_SYNC;
      ACSP_SYNC: if (sclkRise) state_next = ACSP_DATA;
      // Leave on the 64th fall, so the last bit is still sampled
      ACSP_DATA: if (sclkFall && lastBit) state_next = ACSP_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= ACSP_IDLE;
      perCnt_reg <= '0;
      bitCnt_reg <= '0;
      fsync_reg  <= 1'b1;
      sout_reg   <= 1'b0;
      shTx_reg   <= ACSP_WORD_RESET;
      shRx_reg   <= ACSP_WORD_RESET;
      rxWord     <= ACSP_WORD_RESET;
      rxValid    <= 1'b0;
      txTaken    <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      rxValid   <= 1'b0;
      txTaken   <= 1'b0;
      if (sclkRise)
        perCnt_reg <= frameDue ? '0 : perCnt_reg + 1'b1; // see (R04)
      if (sclkRise && state_reg == ACSP_IDLE && frameDue) begin
        fsync_reg <= 1'b0; // see (R02) (R05)
        shTx_reg  <= txWord; // see (R08)
        txTaken   <= 1'b1;
        bitCnt_reg <= '0;
      end
      if (sclkRise && state_reg == ACSP_SYNC)
        fsync_reg <= 1'b1;
      if (sclkRise && state_reg != ACSP_IDLE) begin
        sout_reg <= shTx_reg[63]; // see (R03) (R06)
        shTx_reg <= {shTx_reg[62:0], 1'b0};
      end
      if (sclkFall && state_reg == ACSP_DATA) begin
        shRx_reg   <= {shRx_reg[62:0], link.audioSerialIn}; // see (R07)
        bitCnt_reg <= bitCnt_reg + 1'b1;
        if (lastBit) begin
          rxWord  <= {shRx_reg[62:0], link.audioSerialIn};
          rxValid <= 1'b1;
        end
      end
    end
  end
  assign link.audioBitClock  = sclk_reg;
  assign link.audioFrameSync = fsync_reg;
  assign link.audioSerialOut = sout_reg;
  assign masterTickOut       = mtick_reg;
  assign modemClockTick      = modemTick_reg;
endmodule

// *** common/acsp_pkg.sv ***
/*
 Constants shared by both ends of the audio serial port.
 Assumes one system clock drives both ends; the master clock of the codec
 is modelled as a clock-enable pulse train derived from clk_sys.
*/
// Behaviour
// (R01) Bit clock is master over four times N.
// (R02) Frame sync falls on bit clock rise.
// (R03) Both ends start frame at sync fall.
// (R04) One frame per audio sample period.
// (R05) Frame sync announces device ready both ways.
// (R06) Data moves only inside frame interval.
// (R07) Host sends DAC samples, control, GPIO.
// (R08) Device sends ADC samples, status, GPIO.
// (R09) Master clock between 6.144 and 12.288 MHz.
// (R10) All port clocks derive from master clock.
// (R11) Quadraphonic mode clocks all codecs from master.
// (R12) Reset clears counters, restarts known frame.
// (R13) Divisor N is a parameter, default one; here N is the divN input port, and 0 on it selects one.
package acsp_pkg;
  localparam int          ACSP_FRAME_BITS   = 64;
  localparam int          ACSP_CNT_W        = 6;
  localparam int          ACSP_DIV_W        = 8;
  localparam int          ACSP_MCLK_DIV     = 12;
  localparam int          ACSP_FRAME_PERIOD = 256;
  localparam int          ACSP_PERIOD_W     = 9;
  localparam logic [7:0]  ACSP_N_RESET      = 8'h01;
  localparam int          ACSP_SYNC_BITS    = 1;
  localparam logic [63:0] ACSP_WORD_RESET   = 64'h0;
endpackage

// *** common/acsp_if.sv ***
/*
 Pin-level link between the codec audio port and its host.
 Assumes both ends share clk_sys; the bit clock is a level on a wire.
*/
`timescale 1ns/1ns
interface acsp_if;
  logic audioBitClock;
  logic audioFrameSync;
  logic audioSerialIn;
  logic audioSerialOut;
  modport device (output audioBitClock, output audioFrameSync,
                  output audioSerialOut, input audioSerialIn);
  modport host   (input audioBitClock, input audioFrameSync,
                  input audioSerialOut, output audioSerialIn);
endinterface

// *** src/acsp_host.sv ***
/*
 Host end: follows frame sync, sends 64-bit words, captures replies.
 Assumes the device drives the bit clock and frame sync.
*/
`timescale 1ns/1ns
module acsp_host
  import acsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  input  wire logic [63:0] txWord,
  acsp_if.host             link,
  output logic             txTaken,
  output logic [63:0]      rxWord,
  output logic             rxValid
);
  logic                  sclkD_reg, fsD_reg, active_reg, sin_reg;
  logic [ACSP_CNT_W-1:0] bitCnt_reg;
  logic [63:0]           shTx_reg, shRx_reg;
  wire rise = link.audioBitClock && !sclkD_reg;
  wire fall = !link.audioBitClock && sclkD_reg;
  wire fsFell = fsD_reg && !link.audioFrameSync;
  wire lastBit = bitCnt_reg == ACSP_CNT_W'(ACSP_FRAME_BITS - 1);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclkD_reg  <= 1'b0;
      fsD_reg    <= 1'b1;
      active_reg <= 1'b0;
      sin_reg    <= 1'b0;
      bitCnt_reg <= '0;
      shTx_reg   <= ACSP_WORD_RESET;
      shRx_reg   <= ACSP_WORD_RESET;
      rxWord     <= ACSP_WORD_RESET;
      rxValid    <= 1'b0;
      txTaken    <= 1'b0;
    end else if (clkEn) begin
      sclkD_reg <= link.audioBitClock;
      fsD_reg   <= link.audioFrameSync;
      rxValid   <= 1'b0;
      txTaken   <= 1'b0;
      if (fsFell) begin
        active_reg <= 1'b1; // see (R03)
        shTx_reg   <= txWord; // see (R07)
        txTaken    <= 1'b1;
        bitCnt_reg <= '0;
      end
      if (rise && active_reg) begin
        sin_reg  <= shTx_reg[63]; // see (R06)
        shTx_reg <= {shTx_reg[62:0], 1'b0};
      end
      if (fall && active_reg && link.audioFrameSync) begin
        shRx_reg   <= {shRx_reg[62:0], link.audioSerialOut};
        bitCnt_reg <= bitCnt_reg + 1'b1;
        if (lastBit) begin
          rxWord     <= {shRx_reg[62:0], link.audioSerialOut};
          rxValid    <= 1'b1;
          active_reg <= 1'b0;
        end
      end
    end
  end
  assign link.audioSerialIn = sin_reg;
endmodule

// *** verification/acsp_link_asserts.sv ***
/* Wire checks on the audio port link.
 Assumes MCLK_DIV=1 and N=1, so a bit clock half is two clk_sys. */
`timescale 1ns/1ns
module acsp_link_asserts #(
  parameter int FRAME_PERIOD = 80
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic audioBitClock,
  input wire logic audioFrameSync,
  input wire logic audioSerialIn,
  input wire logic audioSerialOut
);
  logic [11:0] gapCnt_reg;
  logic        seen_reg;
  logic        syncQ_reg;
  wire         syncFall = syncQ_reg & !audioFrameSync;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gapCnt_reg <= 12'h0;
      seen_reg   <= 1'b0;
      syncQ_reg  <= 1'b1;
    end else begin
      gapCnt_reg <= syncFall ? 12'h0 : gapCnt_reg + 12'h1;
      seen_reg   <= seen_reg | syncFall;
      syncQ_reg  <= audioFrameSync;
    end
  end
  //////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  bit_high_a: assert property (
    $rose(audioBitClock) |-> ##2 $fell(audioBitClock))
    else $error("bit clock high phase wrong");
  bit_low_a: assert property (
    $fell(audioBitClock) |-> ##2 $rose(audioBitClock))
    else $error("bit clock low phase wrong");
  sync_edge_a: assert property (
    $fell(audioFrameSync) |-> $rose(audioBitClock))
    else $error("frame sync fell off bit clock rise");
  sync_width_a: assert property ($fell(audioFrameSync) |->
    !audioFrameSync[*4] ##1 (audioFrameSync && $rose(audioBitClock)))
    else $error("frame sync low width wrong");
  frame_rate_a: assert property (syncFall && seen_reg |->
    gapCnt_reg == 12'(FRAME_PERIOD * 4 - 1)) else $error("frame period wrong");
  frame_gap_a: assert property (
    seen_reg |-> gapCnt_reg < 12'(FRAME_PERIOD * 4))
    else $error("frame sync missing");
  out_edge_a: assert property ($changed(audioSerialOut) |->
    audioBitClock || $past(audioBitClock)) else $error("output moved late");
  in_edge_a: assert property ($changed(audioSerialIn) |->
    audioBitClock || $past(audioBitClock)) else $error("input moved late");
  cover property ($fell(audioFrameSync));
  cover property (syncFall && seen_reg);
  cover property ($changed(audioSerialIn));
endmodule

// *** verification/acsp_tb_top.sv ***
/* Testbench joining device and host ends over one link.
 Assumes small timing: MCLK_DIV=1, FRAME_PERIOD=80. */
`timescale 1ns/1ns
module acsp_tb_top;
  import acsp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  divN = 8'h01;
  logic        quadMode = 1'b0;
  logic [63:0] dTx = 64'h0;
  logic [63:0] hTx = 64'h0;
  logic        dTake, dRxV, hRxV, mTick, qTick;
  logic [63:0] dRx, hRx;
  int          n_mismatch = 0;
  int          checks = 0;
  acsp_if link ();
  always #5 clk_sys = ~clk_sys;
  // Master tick every clk to keep runs short
  acsp_device #(.MCLK_DIV(1), .FRAME_PERIOD(80)) u_acsp_device (
    .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .divN(divN),
    .quadMode(quadMode), .txWord(dTx), .link(link), .txTaken(dTake),
    .rxWord(dRx), .rxValid(dRxV), .masterTickOut(mTick),
    .modemClockTick(qTick));
  acsp_host u_acsp_host (
    .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .txWord(hTx),
    .link(link), .txTaken(), .rxWord(hRx), .rxValid(hRxV));
  acsp_link_asserts #(.FRAME_PERIOD(80)) u_acsp_link_asserts (
    .clk_sys(clk_sys), .nrst(nrst), .audioBitClock(link.audioBitClock),
    .audioFrameSync(link.audioFrameSync), .audioSerialIn(link.audioSerialIn),
    .audioSerialOut(link.audioSerialOut));
  //////////////////////////////
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // 0 dev rx, 1 dev load, 2 bit clock fall, 3 host rx
  task automatic waitEv(input int sel);
    int   k;
    logic b0;
    for (k = 0; k < 1000; k++) begin
      b0 = link.audioBitClock;
      @(posedge clk_sys);
      #1;
      if ((sel == 0 && dRxV === 1'b1) || (sel == 1 && dTake === 1'b1) ||
          (sel == 2 && b0 === 1'b1 && link.audioBitClock === 1'b0) ||
          (sel == 3 && hRxV === 1'b1)) break;
    end
    if (k == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic rst(input int n);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    cmp({link.audioFrameSync, link.audioBitClock, link.audioSerialOut, dRxV},
        64'h8);
    @(posedge clk_sys);
    nrst <= 1'b1;
  endtask
  task automatic xfer(input logic [63:0] d, h, input logic [7:0] n);
    logic [63:0] w = 64'h0;
    waitEv(0);
    @(posedge clk_sys);
    dTx  <= d;
    hTx  <= h;
    divN <= n;
    waitEv(1);
    // First fall is still inside the sync bit
    repeat (65) begin
      waitEv(2);
      w = {w[62:0], link.audioSerialOut};
    end
    cmp(w, d);
    // Receive pulse rises on the same edge as the 64th fall
    cmp({63'h0, dRxV}, 64'h1);
    cmp(dRx, h);
    waitEv(3);
    cmp(hRx, d);
  endtask
  task automatic tick_count(input logic q);
    int m = 0;
    int t = 0;
    @(posedge clk_sys);
    quadMode <= q;
    repeat (2) @(posedge clk_sys);
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      m += (mTick === 1'b1);
      t += (qTick === 1'b1);
    end
    cmp(m, 20);
    cmp(t, q ? 20 : 0);
  endtask
  initial begin
    rst(8);
    xfer(64'h8000_0000_0000_0001, 64'hfedc_ba98_7654_3210, 8'h01);
    xfer(64'hffff_ffff_ffff_ffff, 64'h0, 8'h00);
    tick_count(1'b1);
    tick_count(1'b0);
    rst(3);
    xfer(64'h0123_4567_89ab_cdef, 64'h5a5a_a5a5_0f0f_f0f0, 8'h01);
    end_of_test();
  end
endmodule
